/* File: hw/dpc_pkg.sv */
package dpc_pkg;
	// Avalon-MM register byte offsets
	localparam logic [3:0] REG_WIPER    = 4'h0;
	localparam logic [3:0] REG_TERMINAL = 4'h4;
	localparam logic [3:0] REG_CONFIG   = 4'h8;
	localparam logic [3:0] REG_STATUS   = 4'hc;

	// Field positions inside terminal_connect_reg
	localparam int TC_FORCE_OFF = 3;
	localparam int TC_END_A     = 2;
	localparam int TC_WIPER     = 1;
	localparam int TC_END_B     = 0;
	localparam logic [3:0] TC_RESET = 4'hf;

	// Field positions of the config and status registers
	localparam int CFG_BCAST    = 0;
	localparam int ST_HS        = 0;
	localparam int ST_SHUT      = 1;
	localparam int ST_PIN_SHUT  = 2;
	localparam int ST_SELECTED  = 3;

	// Serial address decode
	localparam logic [4:0] DEV_CODE   = 5'h0a; // Arbitrary device code, not a real part
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [4:0] HS_PREFIX  = 5'h01;

	// Command byte: memory_location_field and operation_code_field
	localparam logic [3:0] LOC_WIPER    = 4'h0;
	localparam logic [3:0] LOC_TERMINAL = 4'h4;
	localparam logic [1:0] OP_WRITE     = 2'h0;
	localparam logic [1:0] OP_INCR      = 2'h1;
	localparam logic [1:0] OP_DECR      = 2'h2;
	localparam logic [1:0] OP_READ      = 2'h3;

	// Broadcast command codes, upper six bits of the command byte
	localparam logic [5:0] BC_WR_WIPER = 6'h20;
	localparam logic [5:0] BC_WR_TERM  = 6'h30;
	localparam logic [5:0] BC_INCR     = 6'h21;
	localparam logic [5:0] BC_DECR     = 6'h22;

	// Byte position within a transfer
	localparam logic [1:0] BYTE_ADDR = 2'h0;
	localparam logic [1:0] BYTE_CMD  = 2'h1;
	localparam logic [1:0] BYTE_DATA = 2'h2;

	typedef enum logic [4:0] {
		DPC_IDLE  = 5'b00001,
		DPC_RX    = 5'b00010,
		DPC_ACK   = 5'b00100,
		DPC_TX    = 5'b01000,
		DPC_TXACK = 5'b10000
	} dpc_state_e;

	// Terminal switch states driven to the resistor network
	typedef struct packed {
		logic end_a;
		logic wiper;
		logic end_b;
		logic wiper_to_b;
	} dpc_conn_s;
endpackage : dpc_pkg

/* File: hw/dpc_client.sv */
// Behaviour
// - Shutdown input low: end A open, wiper tied to end B.
// - Serial interface keeps working and executing commands during shutdown.
// - Shutdown never alters wiper or terminal register; outputs resume on exit.
// - Force-off bit at 0 gives the same network state as shutdown input.
// - During force-off the connect bits are ignored but kept.
// - Force-off bit at 1 returns to wiper value and connect bits.
// - Volatile terminal register holds end A, wiper and end B connect bits.
// - Client only; never drives the serial clock.
// - First byte after Start is address: device code, pin bits, direction.
// - Data line sampled on each rising serial clock edge.
// - Data change while clock high is Start or Stop.
// - Standard, fast and high-speed clock rates accepted.
// - No clock stretching; reads answer within bit time.
// - Only 7-bit addressing; 10-bit sequences never acknowledged.
// - Broadcast address acknowledged only when its enable bit is set.
// - Matching address acknowledged low after eight bits; else line left high.
// - Invalid location and operation pair is not acknowledged.
// - A Start resets the command state machine after any error.
// - Start is data falling while clock high; begins a transfer.
// - Repeated Start is decoded as an ordinary Start.
// - Stop is data rising while clock high; resets serial interface.
// - Upper five address bits fixed code; low two from address pins.
// - High-speed entry code not acknowledged; high-speed mode until Stop.
//
// Our own choices: the register addresses and the Avalon-MM register port.
module dpc_client #(
	parameter int              WIPER_W     = 8,
	parameter logic [WIPER_W-1:0] WIPER_RESET = 8'h80
) (
	input  wire logic               core_clk,
	input  wire logic               rst,
	// Avalon-MM slave
	input  wire logic [3:0]         address,
	input  wire logic               read,
	input  wire logic               write,
	input  wire logic [31:0]        writedata,
	output logic      [31:0]        readdata,
	output logic                    waitrequest,
	// Serial pins
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe,
	input  wire logic               addr_pin_low,
	input  wire logic               addr_pin_high,
	input  wire logic               power_down_input_n,
	// Resistor network control
	output dpc_pkg::dpc_conn_s      pot_conn,
	output logic [WIPER_W-1:0]      pot_wiper_code,
	output logic                    hs_mode
);
	// Pin synchronisers: scl, sda, shutdown, address pins
	logic [4:0] pin_s1;
	logic [4:0] pin_s2;
	logic [1:0] line_d;
	logic       scl_s;
	logic       sda_s;
	logic       pdn_s;
	logic [1:0] apin_s;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= 5'h1f;
			pin_s2 <= 5'h1f;
			line_d <= 2'h3;
		end else begin
			pin_s1 <= {scl_in, sda_in, power_down_input_n, addr_pin_high, addr_pin_low};
			pin_s2 <= pin_s1;
			line_d <= pin_s2[4:3];
		end
	end

	assign scl_s  = pin_s2[4];
	assign sda_s  = pin_s2[3];
	assign pdn_s  = pin_s2[2];
	assign apin_s = pin_s2[1:0]; // Static straps, sampled like any pin

	// Line events; clock edges come only from the host
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	assign scl_rise = scl_s & ~line_d[1];
	assign scl_fall = ~scl_s & line_d[1];
	assign start_ev = scl_s & line_d[1] & ~sda_s & line_d[0];
	assign stop_ev  = scl_s & line_d[1] & sda_s & ~line_d[0];

	// Registers
	logic [WIPER_W-1:0] wiper;
	logic [3:0]         terminal_connect_reg;
	logic               bcast_en;

	// Serial engine state
	dpc_pkg::dpc_state_e state;
	logic [2:0]          bit_cnt;
	logic [7:0]          rx_sh;
	logic [7:0]          tx_sh;
	logic [1:0]          byte_pos;
	logic                ack_phase;
	logic                do_ack;
	logic                is_read;
	logic                is_bcast;
	logic                host_ack;
	logic                selected;
	logic                sel_term;
	logic [1:0]          pend_op;
	logic [7:0]          rx_byte;
	assign rx_byte = {rx_sh[6:0], sda_s};

	// Serial-side register updates, decoded at the eighth rising edge
	logic               i2c_wr_wiper;
	logic               i2c_wr_term;
	logic [WIPER_W-1:0] i2c_wiper_val;
	logic [3:0]         i2c_term_val;
	logic               byte_done;
	logic               ack_ok;
	logic               next_sel_term;
	logic [1:0]         next_op;
	logic               next_read;
	logic               next_bcast;

	assign byte_done = (state == dpc_pkg::DPC_RX) && scl_rise && (bit_cnt == 3'h7);

	// Decode the completed byte: acknowledge and register effects
	always_comb begin
		ack_ok        = 1'b0;
		i2c_wr_wiper  = 1'b0;
		i2c_wr_term   = 1'b0;
		i2c_wiper_val = wiper;
		i2c_term_val  = terminal_connect_reg;
		next_sel_term = sel_term;
		next_op       = pend_op;
		next_read     = is_read;
		next_bcast    = is_bcast;
		if (byte_done) begin
			case (byte_pos)
				dpc_pkg::BYTE_ADDR: begin
					next_read  = rx_byte[0];
					next_bcast = 1'b0;
					if (rx_byte[7:1] == {dpc_pkg::DEV_CODE, apin_s}) begin
						ack_ok = 1'b1;
					end else if (rx_byte == dpc_pkg::BCAST_ADDR && bcast_en) begin
						ack_ok     = 1'b1;
						next_bcast = 1'b1;
					end
				end
				dpc_pkg::BYTE_CMD: begin
					if (is_bcast) begin
						ack_ok = 1'b1;
						case (rx_byte[7:2])
							dpc_pkg::BC_WR_WIPER: begin
								next_sel_term = 1'b0;
								next_op       = dpc_pkg::OP_WRITE;
							end
							dpc_pkg::BC_WR_TERM: begin
								next_sel_term = 1'b1;
								next_op       = dpc_pkg::OP_WRITE;
							end
							dpc_pkg::BC_INCR: begin
								next_op = dpc_pkg::OP_INCR;
							end
							dpc_pkg::BC_DECR: begin
								next_op = dpc_pkg::OP_DECR;
							end
							default: begin
								ack_ok = 1'b0;
							end
						endcase
						if (rx_byte[7:2] == dpc_pkg::BC_INCR || rx_byte[7:2] == dpc_pkg::BC_DECR)
							next_sel_term = 1'b0;
					end else begin
						next_op       = rx_byte[3:2];
						next_sel_term = (rx_byte[7:4] == dpc_pkg::LOC_TERMINAL);
						// Step commands make sense on the wiper only
						if (rx_byte[7:4] == dpc_pkg::LOC_WIPER)
							ack_ok = 1'b1;
						else if (rx_byte[7:4] == dpc_pkg::LOC_TERMINAL)
							ack_ok = (rx_byte[3:2] == dpc_pkg::OP_WRITE) ||
							         (rx_byte[3:2] == dpc_pkg::OP_READ);
					end
					if (ack_ok && next_op == dpc_pkg::OP_INCR && !next_sel_term) begin
						i2c_wr_wiper  = 1'b1;
						i2c_wiper_val = (&wiper) ? wiper : wiper + 1'b1;
					end
					if (ack_ok && next_op == dpc_pkg::OP_DECR && !next_sel_term) begin
						i2c_wr_wiper  = 1'b1;
						i2c_wiper_val = (|wiper) ? wiper - 1'b1 : wiper;
					end
				end
				dpc_pkg::BYTE_DATA: begin
					ack_ok = 1'b1;
					if (sel_term) begin
						i2c_wr_term  = 1'b1;
						i2c_term_val = rx_byte[3:0];
					end else begin
						i2c_wr_wiper  = 1'b1;
						i2c_wiper_val = rx_byte[WIPER_W-1:0];
					end
				end
				default: begin
					ack_ok = 1'b0; // Extra broadcast bytes are refused
				end
			endcase
		end
	end

	// Serial state machine; only ever pulls SDA low, never touches SCL
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state     <= dpc_pkg::DPC_IDLE;
			bit_cnt   <= 3'h0;
			rx_sh     <= 8'h00;
			tx_sh     <= 8'h00;
			byte_pos  <= dpc_pkg::BYTE_ADDR;
			ack_phase <= 1'b0;
			do_ack    <= 1'b0;
			is_read   <= 1'b0;
			is_bcast  <= 1'b0;
			host_ack  <= 1'b0;
			selected  <= 1'b0;
			sel_term  <= 1'b0;
			pend_op   <= dpc_pkg::OP_WRITE;
			sda_oe    <= 1'b0;
		end else if (stop_ev) begin
			state    <= dpc_pkg::DPC_IDLE;
			sda_oe   <= 1'b0;
			selected <= 1'b0;
		end else if (start_ev) begin
			state    <= dpc_pkg::DPC_RX;
			bit_cnt  <= 3'h0;
			byte_pos <= dpc_pkg::BYTE_ADDR;
			sda_oe   <= 1'b0;
			selected <= 1'b0;
		end else begin
			case (state)
				dpc_pkg::DPC_RX: begin
					if (scl_rise) begin
						rx_sh   <= rx_byte;
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							state     <= dpc_pkg::DPC_ACK;
							ack_phase <= 1'b0;
							do_ack    <= ack_ok;
							is_read   <= next_read;
							is_bcast  <= next_bcast;
							sel_term  <= next_sel_term;
							pend_op   <= next_op;
						end
					end
				end
				dpc_pkg::DPC_ACK: begin
					if (scl_fall && !ack_phase) begin
						sda_oe    <= do_ack;
						ack_phase <= 1'b1;
					end else if (scl_fall) begin
						bit_cnt <= 3'h0;
						if (!do_ack) begin
							state  <= dpc_pkg::DPC_IDLE; // Wait for a fresh Start
							sda_oe <= 1'b0;
						end else if (byte_pos == dpc_pkg::BYTE_ADDR && is_read) begin
							state    <= dpc_pkg::DPC_TX;
							selected <= 1'b1;
							tx_sh    <= sel_term ? {4'h0, terminal_connect_reg} : 8'(wiper);
							sda_oe   <= sel_term ? 1'b1 : ~wiper[WIPER_W-1];
						end else begin
							state    <= dpc_pkg::DPC_RX;
							selected <= 1'b1;
							sda_oe   <= 1'b0;
							if (byte_pos == dpc_pkg::BYTE_ADDR)
								byte_pos <= dpc_pkg::BYTE_CMD;
							else if (byte_pos == dpc_pkg::BYTE_CMD && pend_op == dpc_pkg::OP_WRITE)
								byte_pos <= dpc_pkg::BYTE_DATA;
							else if (is_bcast)
								byte_pos <= 2'h3; // One command per broadcast
							else
								byte_pos <= dpc_pkg::BYTE_CMD;
						end
					end
				end
				dpc_pkg::DPC_TX: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 3'h1;
						if (!sda_oe && !sda_s) begin
							state  <= dpc_pkg::DPC_IDLE;
							sda_oe <= 1'b0;
						end else if (bit_cnt == 3'h7) begin
							state     <= dpc_pkg::DPC_TXACK;
							ack_phase <= 1'b0;
						end
					end else if (scl_fall) begin
						tx_sh  <= {tx_sh[6:0], 1'b0};
						sda_oe <= ~tx_sh[6];
					end
				end
				dpc_pkg::DPC_TXACK: begin
					if (scl_fall && !ack_phase) begin
						sda_oe    <= 1'b0; // Host owns the acknowledge bit
						ack_phase <= 1'b1;
					end else if (scl_rise) begin
						host_ack <= ~sda_s;
					end else if (scl_fall) begin
						bit_cnt <= 3'h0;
						if (host_ack) begin
							state  <= dpc_pkg::DPC_TX;
							tx_sh  <= sel_term ? {4'h0, terminal_connect_reg} : 8'(wiper);
							sda_oe <= sel_term ? 1'b1 : ~wiper[WIPER_W-1];
						end else begin
							state <= dpc_pkg::DPC_IDLE;
						end
					end
				end
				default: begin
					sda_oe <= 1'b0; // Idle: ignore traffic until a Start
				end
			endcase
		end
	end

	// Open-drain data: only a low level is ever driven
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	// High-speed entry code seen as first byte; left only by Stop
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			hs_mode <= 1'b0;
		else if (stop_ev)
			hs_mode <= 1'b0;
		else if (byte_done && byte_pos == dpc_pkg::BYTE_ADDR &&
		         rx_byte[7:3] == dpc_pkg::HS_PREFIX)
			hs_mode <= 1'b1;
	end

	// Avalon handshake: one wait cycle, then a single low-waitrequest cycle
	logic bus_take;
	assign bus_take = (read | write) & ~waitrequest;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			waitrequest <= 1'b1;
		else
			waitrequest <= ~((read | write) & waitrequest);
	end

	// Wiper register; serial writes win a same-cycle clash with the bus
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			wiper <= WIPER_RESET;
		else if (i2c_wr_wiper)
			wiper <= i2c_wiper_val;
		else if (bus_take && write && address == dpc_pkg::REG_WIPER)
			wiper <= writedata[WIPER_W-1:0];
	end

	// Volatile terminal register, never touched by shutdown
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			terminal_connect_reg <= dpc_pkg::TC_RESET;
		else if (i2c_wr_term)
			terminal_connect_reg <= i2c_term_val;
		else if (bus_take && write && address == dpc_pkg::REG_TERMINAL)
			terminal_connect_reg <= writedata[3:0];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			bcast_en <= 1'b0;
		else if (bus_take && write && address == dpc_pkg::REG_CONFIG)
			bcast_en <= writedata[dpc_pkg::CFG_BCAST];
	end

	// Shutdown request from either source
	logic shut;
	assign shut = ~pdn_s | ~terminal_connect_reg[dpc_pkg::TC_FORCE_OFF];

	// Read data registered while waitrequest is still high
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if (read && waitrequest) begin
			case (address)
				dpc_pkg::REG_WIPER:    readdata <= 32'(wiper);
				dpc_pkg::REG_TERMINAL: readdata <= 32'(terminal_connect_reg);
				dpc_pkg::REG_CONFIG:   readdata <= 32'(bcast_en);
				dpc_pkg::REG_STATUS: begin
					readdata <= 32'({selected, ~pdn_s, shut, hs_mode});
				end
				default:               readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Network switches; connect bits are masked, not cleared, in shutdown
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pot_conn       <= '0;
			pot_wiper_code <= WIPER_RESET;
		end else begin
			pot_wiper_code       <= wiper;
			pot_conn.end_a       <= ~shut & terminal_connect_reg[dpc_pkg::TC_END_A];
			pot_conn.wiper       <= shut | terminal_connect_reg[dpc_pkg::TC_WIPER];
			pot_conn.end_b       <= shut | terminal_connect_reg[dpc_pkg::TC_END_B];
			pot_conn.wiper_to_b  <= shut;
		end
	end
endmodule : dpc_client

/* File: tb/dpc_client_properties.sv */
module dpc_client_properties (
	input wire logic               core_clk,
	input wire logic               rst,
	input wire logic               read,
	input wire logic               write,
	input wire logic               waitrequest,
	input wire logic               scl_in,
	input wire logic               sda_in,
	input wire logic               sda_out,
	input wire logic               sda_oe,
	input wire logic               power_down_input_n,
	input wire dpc_pkg::dpc_conn_s pot_conn,
	input wire logic               hs_mode
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Bus conditions seen through the core clock
	sequence s_start;
		$fell(sda_in) && scl_in;
	endsequence
	sequence s_stop;
		$rose(sda_in) && scl_in;
	endsequence
	// Long enough for the pin synchroniser to settle
	sequence s_pin_low;
		!power_down_input_n [*5];
	endsequence

	a_pin_shut: assert property (s_pin_low |-> pot_conn == 4'b0111)
		else $error("shutdown pin low but network not in shutdown form");
	a_shut_form: assert property (pot_conn.wiper_to_b |-> pot_conn == 4'b0111)
		else $error("wiper tied to end B without full shutdown form");
	a_open_drain: assert property (!sda_out)
		else $error("data output not held at zero");
	a_start_rel: assert property (s_start |-> ##[1:6] !sda_oe)
		else $error("data line still held after a start");
	a_stop_hs: assert property (s_stop |-> ##[1:6] !hs_mode)
		else $error("high speed flag survives a stop");
	a_hs_nack: assert property ($rose(hs_mode) |-> !sda_oe [*8])
		else $error("high speed entry code acknowledged");
	a_bus_ans: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus request not answered in one cycle");
	a_wait_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
endmodule : dpc_client_properties

/* File: tb/dpc_host_model.sv */
module dpc_host_model (
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda_line
);
	timeunit 1ns;
	timeprecision 100ps;

	// Clock stands high and data released outside frames
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// Odd offset keeps link edges away from core edges
	task automatic start_cond();
		#13;
		sda_drv = 1'b1;
		#100 scl = 1'b1;
		#100 sda_drv = 1'b0;
		#100 scl = 1'b0;
		#100;
	endtask : start_cond

	task automatic stop_cond();
		sda_drv = 1'b0;
		#100 scl = 1'b1;
		#100 sda_drv = 1'b1;
		#200;
	endtask : stop_cond

	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		#100 scl = 1'b1;
		#100 r = sda_line;
		#100 scl = 1'b0;
		#100;
	endtask : bit_io

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : send_byte

	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(!ack, r);
	endtask : recv_byte
endmodule : dpc_host_model

/* File: tb/tb_dpc_client.sv */
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t got %h want %h", $time, a, e); end end

module tb_dpc_client;
	timeunit 1ns;
	timeprecision 100ps;
	logic               core_clk, rst, read, write, power_down_input_n;
	logic               addr_pin_low, addr_pin_high, waitrequest, sda_out, sda_oe;
	logic               hs_mode, scl, sda_drv, ack;
	logic [3:0]         address;
	logic [31:0]        writedata, readdata, rnd, exp_rd;
	logic [7:0]         pot_wiper_code, val, rb, dev;
	logic [7:0]         bad[4];
	dpc_pkg::dpc_conn_s pot_conn;
	logic [31:0]        exp_q[$];
	int                 mismatches, checks, cycles;
	integer             seed = 32'hf978f40a;
	wire                sda_line = sda_oe ? 1'b0 : sda_drv;

	dpc_client dut (.core_clk(core_clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_pin_low(addr_pin_low), .addr_pin_high(addr_pin_high),
		.power_down_input_n(power_down_input_n), .pot_conn(pot_conn),
		.pot_wiper_code(pot_wiper_code), .hs_mode(hs_mode));
	dpc_host_model host (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// Hang guard, far above the few thousand cycles needed
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end

	// Read results taken at the accepting edge, oldest note first
	// Note taken once, so a mismatch print cannot pop a second entry
	always @(posedge core_clk) if (read && waitrequest === 1'b0) begin
		exp_rd = exp_q.pop_front();
		`CHK(readdata, exp_rd)
	end

	// Request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		do @(posedge core_clk); while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic sb(input logic [7:0] d, input logic e);
		host.send_byte(d, ack);
		`CHK(ack, e)
	endtask : sb
	task automatic settle();
		repeat (6) @(posedge core_clk);
	endtask : settle

	initial begin
		rst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0;
		power_down_input_n = 1'b1;
		rnd = $random(seed);
		// Straps fixed for the whole run
		{addr_pin_high, addr_pin_low} = rnd[1:0];
		dev = {dpc_pkg::DEV_CODE, rnd[1:0], 1'b0};
		val = rnd[15:8];
		bad = '{dev ^ 8'h02, dev ^ 8'h04, 8'hf0, dpc_pkg::BCAST_ADDR};
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		settle();
		`CHK(pot_conn, 4'b1110)
		rd(dpc_pkg::REG_WIPER, 32'h80);
		rd(dpc_pkg::REG_TERMINAL, 32'hf);
		rd(dpc_pkg::REG_CONFIG, 32'h0);
		rd(4'h2, 32'h0);
		// Wiper write, then read back over the link
		host.start_cond();
		sb(dev, 1'b1);
		sb({dpc_pkg::LOC_WIPER, dpc_pkg::OP_WRITE, 2'b00}, 1'b1);
		sb(val, 1'b1);
		host.stop_cond();
		settle();
		`CHK(pot_wiper_code, val)
		host.start_cond();
		sb(dev | 8'h01, 1'b1);
		host.recv_byte(1'b0, rb);
		`CHK(rb, val)
		host.stop_cond();
		// Foreign, ten-bit and disabled broadcast addresses
		for (int i = 0; i < 4; i++) begin
			host.start_cond();
			sb(bad[i], 1'b0);
			host.stop_cond();
		end
		bus(1'b1, dpc_pkg::REG_CONFIG, 32'h1);
		host.start_cond();
		sb(dpc_pkg::BCAST_ADDR, 1'b1);
		sb({dpc_pkg::BC_INCR, 2'b00}, 1'b1);
		host.stop_cond();
		settle();
		val = (val == 8'hff) ? val : val + 8'h01;
		`CHK(pot_wiper_code, val)
		// Broadcast wiper write, refused extra byte, then a direct step down
		host.start_cond();
		sb(dpc_pkg::BCAST_ADDR, 1'b1);
		sb({dpc_pkg::BC_WR_WIPER, 2'b00}, 1'b1);
		val = val ^ 8'h5a;
		sb(val, 1'b1);
		sb(val, 1'b0);
		host.start_cond();
		sb(dev, 1'b1);
		sb({dpc_pkg::LOC_WIPER, dpc_pkg::OP_DECR, 2'b00}, 1'b1);
		host.stop_cond();
		settle();
		val = (val == 8'h00) ? val : val - 8'h01;
		`CHK(pot_wiper_code, val)
		// Pin shutdown with traffic, a refused command and a restart
		@(posedge core_clk) power_down_input_n <= 1'b0;
		settle();
		`CHK(pot_conn, 4'b0111)
		host.start_cond();
		sb(dev, 1'b1);
		sb({dpc_pkg::LOC_TERMINAL, dpc_pkg::OP_INCR, 2'b00}, 1'b0);
		host.start_cond();
		sb(dev, 1'b1);
		sb({dpc_pkg::LOC_TERMINAL, dpc_pkg::OP_WRITE, 2'b00}, 1'b1);
		sb(8'h0d, 1'b1);
		host.stop_cond();
		settle();
		`CHK(pot_conn, 4'b0111)
		rd(dpc_pkg::REG_TERMINAL, 32'hd);
		rd(dpc_pkg::REG_WIPER, {24'h0, val});
		rd(dpc_pkg::REG_STATUS, 32'h6);
		@(posedge core_clk) power_down_input_n <= 1'b1;
		settle();
		`CHK(pot_conn, 4'b1010)
		// Force-off bit round trip
		bus(1'b1, dpc_pkg::REG_TERMINAL, 32'h6);
		settle();
		`CHK(pot_conn, 4'b0111)
		rd(dpc_pkg::REG_TERMINAL, 32'h6);
		bus(1'b1, dpc_pkg::REG_TERMINAL, 32'he);
		settle();
		`CHK(pot_conn, 4'b1100)
		`CHK(pot_wiper_code, val)
		// Terminal register selected by a read command, fetched after Sr
		host.start_cond();
		sb(dev, 1'b1);
		sb({dpc_pkg::LOC_TERMINAL, dpc_pkg::OP_READ, 2'b00}, 1'b1);
		host.start_cond();
		sb(dev | 8'h01, 1'b1);
		host.recv_byte(1'b0, rb);
		`CHK(rb, 8'h0e)
		host.stop_cond();
		// High-speed entry is refused yet switches the mode until Stop
		host.start_cond();
		sb({dpc_pkg::HS_PREFIX, rnd[18:16]}, 1'b0);
		settle();
		`CHK(hs_mode, 1'b1)
		rd(dpc_pkg::REG_STATUS, 32'h1);
		host.stop_cond();
		settle();
		`CHK(hs_mode, 1'b0)
		test_done();
	end
endmodule : tb_dpc_client

bind dpc_client dpc_client_properties u_props (.core_clk(core_clk), .rst(rst), .read(read),
	.write(write), .waitrequest(waitrequest), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .power_down_input_n(power_down_input_n),
	.pot_conn(pot_conn), .hs_mode(hs_mode));
